// [logic/bias_regs_defines.svh]
`ifndef BIAS_REGS_DEFINES_SVH
`define BIAS_REGS_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_RESET_IDENTITY 8'h00
`define IDX_BIAS_CONTROL 8'h04
`define IDX_MIDPOINT_CONTROL 8'h05
`define IDX_MIC_THRESHOLD 8'h06

// Arbitrary neutral identification value
`define IDENTITY_WORD_VALUE 16'h5a3c

// Field positions
`define MAIN_BIAS_BIT 0
`define MID_BUF_BIT 6
`define MID_DIV_LO 1
`define MID_DIV_HI 2
`define MID_SRC_BIT 0
`define DET_LVL_LO 4
`define DET_LVL_HI 6
`define SHORT_LVL_LO 2
`define SHORT_LVL_HI 3

// Reset values
`define RST_BIT 1'b0
`define RST_DIV 2'h0
`define RST_DET 3'h0
`define RST_SHORT 2'h0

`endif

// [logic/bias_regs_pkg.sv]
package bias_regs_pkg;

    typedef enum logic [1:0] {
        MID_OFF = 2'b00,
        MID_NORMAL = 2'b01,
        MID_STANDBY = 2'b10,
        MID_FAST = 2'b11
    } midpoint_divider_type;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_type;

endpackage

// [logic/bias_field.sv]
`include "bias_regs_defines.svh"

// One software field with reset value, cleared by the soft reset
module bias_field
    import bias_regs_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] value_o
);
    typedef struct packed {
        logic [WIDTH-1:0] value;
    } field_state_type;

    field_state_type state_q;
    field_state_type state_d;

    always_comb begin
        state_d = state_q;
        if (clear_i) begin
            state_d.value = RESET_VALUE;
        end else if (load_i) begin
            state_d.value = data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= '{value: RESET_VALUE};
        end else begin
            state_q <= state_d;
        end
    end

    assign value_o = state_q.value;
endmodule

// [logic/bias_reset_id_regs.sv]
// Design decision made here: the Wishbone interface to the registers.
`include "bias_regs_defines.svh"

module bias_reset_id_regs
    import bias_regs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic main_bias_enable_o,
    output logic midpoint_buffer_enable_o,
    output logic [1:0] midpoint_divider_select_o,
    output logic midpoint_source_enable_o,
    output logic [2:0] mic_current_detect_level_o,
    output logic [1:0] mic_short_detect_level_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus state

    typedef struct packed {
        bus_state_type phase;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } bus_regs_type;

    bus_regs_type bus_q;
    bus_regs_type bus_d;

    logic request;
    logic [7:0] index;
    logic aligned;
    logic hit_id;
    logic hit_bias;
    logic hit_mid;
    logic hit_mic;
    logic mapped;
    logic write_go;
    logic soft_clear;
    logic lane0;
    logic bias_val;
    logic buf_val;
    logic [1:0] div_val;
    logic src_val;
    logic [2:0] det_val;
    logic [1:0] short_val;
    logic [15:0] read_word;

    assign request = wb_cyc_i && wb_stb_i && (bus_q.phase == BUS_IDLE);
    assign index = wb_adr_i[9:2];
    assign aligned = (wb_adr_i[1:0] == 2'h0);
    assign hit_id = aligned && (index == `IDX_RESET_IDENTITY);
    assign hit_bias = aligned && (index == `IDX_BIAS_CONTROL);
    assign hit_mid = aligned && (index == `IDX_MIDPOINT_CONTROL);
    assign hit_mic = aligned && (index == `IDX_MIC_THRESHOLD);
    assign mapped = hit_id || hit_bias || hit_mid || hit_mic;
    // Writes land once, on the cycle the request is taken
    assign write_go = request && wb_we_i && mapped;
    // Any data, any lanes: the write itself is the command
    assign soft_clear = write_go && hit_id;
    // All fields live in the low byte
    assign lane0 = wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////////
    // Fields

    bias_field #(.WIDTH(1), .RESET_VALUE(`RST_BIT)) u_main_bias (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(soft_clear),
        .load_i(write_go && hit_bias && lane0),
        .data_i(wb_dat_i[`MAIN_BIAS_BIT]),
        .value_o(bias_val)
    );

    bias_field #(.WIDTH(1), .RESET_VALUE(`RST_BIT)) u_mid_buffer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(soft_clear),
        .load_i(write_go && hit_mid && lane0),
        .data_i(wb_dat_i[`MID_BUF_BIT]),
        .value_o(buf_val)
    );

    bias_field #(.WIDTH(2), .RESET_VALUE(`RST_DIV)) u_mid_divider (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(soft_clear),
        .load_i(write_go && hit_mid && lane0),
        .data_i(wb_dat_i[`MID_DIV_HI:`MID_DIV_LO]),
        .value_o(div_val)
    );

    bias_field #(.WIDTH(1), .RESET_VALUE(`RST_BIT)) u_mid_source (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(soft_clear),
        .load_i(write_go && hit_mid && lane0),
        .data_i(wb_dat_i[`MID_SRC_BIT]),
        .value_o(src_val)
    );

    bias_field #(.WIDTH(3), .RESET_VALUE(`RST_DET)) u_det_level (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(soft_clear),
        .load_i(write_go && hit_mic && lane0),
        .data_i(wb_dat_i[`DET_LVL_HI:`DET_LVL_LO]),
        .value_o(det_val)
    );

    bias_field #(.WIDTH(2), .RESET_VALUE(`RST_SHORT)) u_short_level (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(soft_clear),
        .load_i(write_go && hit_mic && lane0),
        .data_i(wb_dat_i[`SHORT_LVL_HI:`SHORT_LVL_LO]),
        .value_o(short_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        read_word = 16'h0000;
        if (hit_id) begin
            read_word = `IDENTITY_WORD_VALUE;
        end else if (hit_bias) begin
            read_word[`MAIN_BIAS_BIT] = bias_val;
        end else if (hit_mid) begin
            read_word[`MID_BUF_BIT] = buf_val;
            read_word[`MID_DIV_HI:`MID_DIV_LO] = div_val;
            read_word[`MID_SRC_BIT] = src_val;
        end else if (hit_mic) begin
            read_word[`DET_LVL_HI:`DET_LVL_LO] = det_val;
            read_word[`SHORT_LVL_HI:`SHORT_LVL_LO] = short_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: answer registered one cycle after the request is taken; requests are ignored while it shows

    always_comb begin
        bus_d = bus_q;
        bus_d.ack = 1'b0;
        bus_d.err = 1'b0;
        case (bus_q.phase)
            BUS_IDLE: begin
                if (request) begin
                    bus_d.phase = BUS_ACK;
                    bus_d.ack = mapped;
                    bus_d.err = !mapped;
                    bus_d.rdata = {16'h0000, read_word};
                end
            end
            BUS_ACK: begin
                // Drop answer so a held request is not taken twice
                bus_d.phase = BUS_IDLE;
            end
            default: begin
                bus_d.phase = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_q <= '{phase: BUS_IDLE, ack: 1'b0, err: 1'b0, rdata: 32'h0000_0000};
        end else begin
            bus_q <= bus_d;
        end
    end

    assign wb_ack_o = bus_q.ack;
    assign wb_err_o = bus_q.err;
    assign wb_dat_o = bus_q.rdata;
    assign main_bias_enable_o = bias_val;
    assign midpoint_buffer_enable_o = buf_val;
    assign midpoint_divider_select_o = div_val;
    assign midpoint_source_enable_o = src_val;
    assign mic_current_detect_level_o = det_val;
    assign mic_short_detect_level_o = short_val;
endmodule

// [bench/bias_checker_assertions.sv]
`include "bias_regs_defines.svh"
module bias_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic main_bias_enable_o,
    input wire logic midpoint_buffer_enable_o,
    input wire logic [1:0] midpoint_divider_select_o,
    input wire logic midpoint_source_enable_o,
    input wire logic [2:0] mic_current_detect_level_o,
    input wire logic [1:0] mic_short_detect_level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tk;
    logic wr;
    logic rd;
    logic w;
    logic [9:0] f;
    // Slave ignores the bus in the cycle of its own answer
    assign tk = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
    assign wr = tk & wb_we_i;
    assign rd = tk & !wb_we_i;
    assign w = wr & wb_sel_i[0];
    assign f = {main_bias_enable_o, midpoint_buffer_enable_o, midpoint_divider_select_o,
        midpoint_source_enable_o, mic_current_detect_level_o, mic_short_detect_level_o};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////
    a_soft_reset:
        assert property (wr && wb_adr_i == 10'h0 |=> f == 10'h0) else $error("Fields kept");
    a_id_read:
        assert property (rd && wb_adr_i == 10'h0 |=> wb_ack_o
            && wb_dat_o == {16'h0, `IDENTITY_WORD_VALUE}) else $error("Bad id word");
    a_bias_write:
        assert property (w && wb_adr_i == 10'h010 |=> main_bias_enable_o == $past(wb_dat_i[0]))
            else $error("Bias bit not loaded");
    a_mid_write:
        assert property (w && wb_adr_i == 10'h014 |=> f[8:5] == $past({wb_dat_i[6],
            wb_dat_i[2:0]})) else $error("Midpoint fields not loaded");
    a_mic_write:
        assert property (w && wb_adr_i == 10'h018 |=> f[4:0] == $past(wb_dat_i[6:2]))
            else $error("Mic levels not loaded");
    a_fields_hold:
        assert property (!wr |=> $stable(f)) else $error("Field moved without write");
    a_read_mask:
        assert property (rd && wb_adr_i == 10'h010 |=> wb_ack_o
            && wb_dat_o == {31'h0, main_bias_enable_o}) else $error("Bias read unmasked");
    a_unmapped_err:
        assert property (tk && wb_adr_i[1:0] != 2'h0 |=> wb_err_o && !wb_ack_o && $stable(f))
            else $error("Misaligned access accepted");
endmodule
bind bias_reset_id_regs bias_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .main_bias_enable_o,
    .midpoint_buffer_enable_o, .midpoint_divider_select_o, .midpoint_source_enable_o,
    .mic_current_detect_level_o, .mic_short_detect_level_o);

// [bench/bias_reset_id_regs_test.sv]
`include "bias_regs_defines.svh"
module bias_reset_id_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rdat;
    logic wb_ack_o, wb_err_o, rerr, main_bias_enable_o, midpoint_buffer_enable_o;
    logic midpoint_source_enable_o;
    logic [1:0] midpoint_divider_select_o, mic_short_detect_level_o;
    logic [2:0] mic_current_detect_level_o;
    logic [9:0] f;
    int errors = 0;
    int checks = 0;
    bias_reset_id_regs u_bias_reset_id_regs (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .main_bias_enable_o,
        .midpoint_buffer_enable_o, .midpoint_divider_select_o, .midpoint_source_enable_o,
        .mic_current_detect_level_o, .mic_short_detect_level_o);
    assign f = {main_bias_enable_o, midpoint_buffer_enable_o, midpoint_divider_select_o,
        midpoint_source_enable_o, mic_current_detect_level_o, mic_short_detect_level_o};
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        rerr = wb_err_o;
        if (n >= 20) errors++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] want);
        xfer(1'b0, a, 32'h0, 4'hf);
        chk("read data", rdat, want);
    endtask
    task automatic summarize();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("reset fields", f, 32'h0);
        rd(10'h000, {16'h0, `IDENTITY_WORD_VALUE});
        xfer(1'b1, 10'h010, 32'hffff_ffff, 4'hf);
        chk("bias on", f, 32'h200);
        rd(10'h010, 32'h1);
        // Byte lane 0 off: write must be dropped
        xfer(1'b1, 10'h010, 32'h0, 4'he);
        chk("bias kept", f, 32'h200);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 10'h014, 32'hffff_ff39 | (i << 1) | ((i & 1) << 6), 4'hf);
            rd(10'h014, (i << 1) | ((i & 1) << 6) | 1);
            chk("midpoint", f[8:5], ((i & 1) << 3) | (i << 1) | 1);
        end
        for (int j = 0; j < 8; j++) begin
            xfer(1'b1, 10'h018, 32'hffff_ff83 | (j << 4) | ((j & 3) << 2), 4'hf);
            rd(10'h018, (j << 4) | ((j & 3) << 2));
            chk("mic levels", f[4:0], (j << 2) | (j & 3));
        end
        xfer(1'b0, 10'h01c, 32'h0, 4'hf);
        chk("unmapped err", rerr, 32'h1);
        xfer(1'b1, 10'h011, 32'h0, 4'hf);
        chk("misaligned", {rerr, f}, 32'h7ff);
        xfer(1'b1, 10'h000, 32'h0000_1234, 4'h0);
        chk("soft reset", f, 32'h0);
        rd(10'h014, 32'h0);
        summarize();
    end
    initial begin
        #100000;
        errors++;
        summarize();
    end
endmodule
